//--- bench/sscp_link_asserts.sv
// link protocol checker for the serial command port
`timescale 1ns/1ps
module sscp_link_asserts (
  // system clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  // all checks sample on the system clock outside reset
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // miso ownership follows select
  a_miso_released: assert property (ss_n |-> !miso_oe)
    else $error("miso driven while deselected");
  a_miso_driven: assert property (!ss_n |-> miso_oe)
    else $error("miso not driven while selected");
  a_line_pullup: assert property (!miso_oe |-> miso_line)
    else $error("released miso line not high");
  // clock idles high, halves last at least three system clocks
  a_sclk_idle_high: assert property (ss_n |-> sclk)
    else $error("serial clock low while deselected");
  a_sclk_high_time: assert property ($rose(sclk) |-> sclk [*3])
    else $error("serial clock high half too short");
  a_sclk_low_time: assert property ($fell(sclk) |-> !sclk [*3])
    else $error("serial clock low half too short");
  // select lead and trail around clock activity
  a_select_lead: assert property ($fell(ss_n) |-> sclk [*2])
    else $error("clock edge too soon after select");
  a_select_trail: assert property ($rose(ss_n) |-> $past(sclk, 1) && $past(sclk, 2))
    else $error("select released too soon after clock edge");
  a_mosi_hold: assert property ($rose(sclk) && !ss_n |-> $stable(mosi) ##1 $stable(mosi))
    else $error("mosi moved around the sample edge");

  // main scenarios reached
  c_frame_start: cover property ($fell(ss_n));
  c_miso_low: cover property (miso_oe && !miso);
  c_frame_end: cover property ($rose(ss_n));
endmodule : sscp_link_asserts

//--- bench/tb_spi_slave_command_port.sv
// self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ps
module tb_spi_slave_command_port;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] val;
    logic [7:0] rd;
  } sscp_tb_row_t;

  // clock, reset and apb
  logic                               pclk;
  logic                               presetn;
  logic                               psel;
  logic                               penable;
  logic                               pwrite;
  logic [11:0]                        paddr;
  logic [31:0]                        pwdata;
  logic [31:0]                        prdata;
  logic                               pready;
  logic                               pslverr;
  // device side
  logic [7:0]                         twowire_transfer_status;
  logic [7:0]                         receive_buffer_count;
  logic                               twowire_master_busy;
  logic                               twowire_pause;
  logic                               own_addr_ack_block;
  logic [sscp_pkg::NUM_REGS-1:0][7:0] reg_value;
  // bench state
  int                                 fail_count;
  int                                 num_checks;
  int                                 cycles;
  int                                 ncap;
  logic [7:0]                         cap;
  logic                               lsb;
  logic [7:0]                         rx;
  logic [31:0]                        q;
  logic [7:0]                         model [10];
  sscp_tb_row_t                       rows [11];

  sscp_link_if sscp_link_if_i ();

  sscp_host sscp_host_i (
    .link(sscp_link_if_i), .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  sscp_device sscp_device_i (
    .link(sscp_link_if_i), .pclk(pclk), .presetn(presetn),
    .twowire_transfer_status(twowire_transfer_status),
    .receive_buffer_count(receive_buffer_count), .twowire_master_busy(twowire_master_busy),
    .twowire_pause(twowire_pause), .own_addr_ack_block(own_addr_ack_block),
    .reg_value(reg_value));

  sscp_link_asserts sscp_link_asserts_i (
    .pclk(pclk), .presetn(presetn), .sclk(sscp_link_if_i.sclk), .mosi(sscp_link_if_i.mosi),
    .ss_n(sscp_link_if_i.ss_n), .miso(sscp_link_if_i.miso),
    .miso_oe(sscp_link_if_i.miso_oe), .miso_line(sscp_link_if_i.miso_line));

  // system clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      give_verdict();
    end
  end

  // mosi bits in arrival order, seen on the wire
  always @(posedge sscp_link_if_i.sclk) begin
    if (sscp_link_if_i.ss_n === 1'b0) begin
      cap = {cap[6:0], sscp_link_if_i.mosi};
      ncap++;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    chk("slave error", 32'h0, {31'h0, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one link byte: order it, wait for idle, fetch the reply byte
  task automatic xbyte(input logic [7:0] b, input logic keep, output logic [7:0] r);
    logic [31:0] s;
    logic [7:0]  rev;
    int          n;
    rev  = {<<{b}};
    ncap = 0;
    apb(1'b1, sscp_pkg::HOST_ADDR_XFER, {23'h0, keep, b}, s);
    repeat (2) @(posedge pclk);
    n = 0;
    s = 32'h0000_0001;
    while (s[sscp_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 400) begin
      apb(1'b0, sscp_pkg::HOST_ADDR_STATUS, 32'h0, s);
      n++;
    end
    chk("busy clears", 32'h0, {31'h0, s[sscp_pkg::STAT_BUSY_BIT]});
    apb(1'b0, sscp_pkg::HOST_ADDR_RXDATA, 32'h0, s);
    r = s[7:0];
    chk("mosi bit count", 32'h8, ncap);
    chk("mosi bit order", {24'h0, lsb ? rev : b}, {24'h0, cap});
  endtask : xbyte

  task automatic chk_regs();
    repeat (6) @(posedge pclk);
    for (int j = 0; j < 10; j++) chk("register file", {24'h0, model[j]}, {24'h0, reg_value[j]});
  endtask : chk_regs

  // write a register, compare the file, read it back
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
    logic [7:0] r;
    xbyte(sscp_pkg::CMD_WRITE_REG, 1'b1, r);
    xbyte(a, 1'b1, r);
    xbyte(v, 1'b0, r);
    if (a <= sscp_pkg::LAST_REG_ADDR && e === v) model[a[3:0]] = v;
    chk_regs();
    xbyte(sscp_pkg::CMD_READ_REG, 1'b1, r);
    xbyte(a, 1'b1, r);
    xbyte(8'hC7, 1'b1, r);
    xbyte(8'h00, 1'b0, r);
    chk("read reply", {24'h0, e}, {24'h0, r});
  endtask : wr_rd

  // bit order for the device, then for the host
  task automatic set_order(input logic [7:0] c, input logic host_lsb);
    logic [7:0]  r;
    logic [31:0] s;
    xbyte(sscp_pkg::CMD_LINK_CFG, 1'b1, r);
    xbyte(c, 1'b0, r);
    apb(1'b1, sscp_pkg::HOST_ADDR_CONFIG, {16'h0, sscp_pkg::HOST_HALF_RESET, 7'h0, host_lsb}, s);
    lsb = host_lsb;
  endtask : set_order

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    twowire_transfer_status = 8'h6B;
    receive_buffer_count = 8'h2E;
    twowire_master_busy = 1'b0;
    lsb = 1'b0;
    model = '{8'h00, 8'h00, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rows = '{'{8'h00, 8'h5A, 8'h5A}, '{8'h01, 8'hA5, 8'hA5}, '{8'h02, 8'h3C, 8'h3C},
             '{8'h03, 8'hFF, 8'hFF}, '{8'h04, 8'h77, 8'h6B}, '{8'h05, 8'h81, 8'h81},
             '{8'h06, 8'h12, 8'h2E}, '{8'h07, 8'hC3, 8'hC3}, '{8'h08, 8'h0F, 8'h0F},
             '{8'h09, 8'hF0, 8'hF0}, '{8'h0A, 8'h55, 8'h00}};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // status registers follow their inputs once out of reset
    model[4] = 8'h6B;
    model[6] = 8'h2E;
    chk_regs();
    apb(1'b0, sscp_pkg::HOST_ADDR_CONFIG, 32'h0, q);
    chk("host config reset", 32'h0000_0400, q);
    apb(1'b0, 12'h010, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    foreach (rows[i]) wr_rd(rows[i].addr, rows[i].val, rows[i].rd);
    // bit order switches, an unknown order byte in between
    set_order(sscp_pkg::CFG_LSB_FIRST, 1'b1);
    wr_rd(8'h05, 8'h1E, 8'h1E);
    set_order(8'h55, 1'b1);
    wr_rd(8'h03, 8'h8C, 8'h8C);
    set_order(sscp_pkg::CFG_MSB_FIRST, 1'b0);
    wr_rd(8'h01, 8'h3A, 8'h3A);
    // byte after the value byte is a new command, not a second write
    xbyte(sscp_pkg::CMD_WRITE_REG, 1'b1, rx);
    xbyte(8'h07, 1'b1, rx);
    xbyte(8'h11, 1'b1, rx);
    xbyte(8'h99, 1'b0, rx);
    model[7] = 8'h11;
    chk_regs();
    // deselect in mid command drops it
    xbyte(sscp_pkg::CMD_WRITE_REG, 1'b1, rx);
    xbyte(8'h05, 1'b0, rx);
    xbyte(8'h99, 1'b0, rx);
    chk_regs();
    // commands while the two-wire master is busy, then idle
    twowire_master_busy <= 1'b1;
    xbyte(sscp_pkg::CMD_WRITE_REG, 1'b1, rx);
    chk("pause mid command", 32'h1, {31'h0, twowire_pause});
    chk("ack block while busy", 32'h0, {31'h0, own_addr_ack_block});
    xbyte(8'h08, 1'b1, rx);
    xbyte(8'h66, 1'b0, rx);
    model[8] = 8'h66;
    chk_regs();
    chk("pause after command", 32'h0, {31'h0, twowire_pause});
    twowire_master_busy <= 1'b0;
    xbyte(sscp_pkg::CMD_READ_REG, 1'b1, rx);
    chk("ack block mid command", 32'h1, {31'h0, own_addr_ack_block});
    chk("pause on idle bus", 32'h0, {31'h0, twowire_pause});
    xbyte(8'h08, 1'b1, rx);
    xbyte(8'hC7, 1'b1, rx);
    xbyte(8'h00, 1'b0, rx);
    chk("read reply", 32'h66, {24'h0, rx});
    chk("miso released", 32'h1, {31'h0, sscp_link_if_i.miso_line});
    // mid-run reset restores the register file, then the link works msb first
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    model = '{8'h00, 8'h00, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int j = 0; j < 10; j++) chk("reset", {24'h0, model[j]}, {24'h0, reg_value[j]});
    presetn <= 1'b1;
    model[4] = 8'h6B;
    model[6] = 8'h2E;
    wr_rd(8'h02, 8'h9D, 8'h9D);
    give_verdict();
  end
endmodule : tb_spi_slave_command_port

//--- hdl/sscp_device.sv
// device end: serial command decoder and byte-wide register file
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// Contract
// [R1] link active only while select is low
// [R2] master supplies clock and both data bytes
// [R3] clock idles high between transfers
// [R4] select may be tied low permanently
// [R5] master avoids 100 to 300 kHz clocks; the host only clamps each clock half to at least 3 system clocks
// [R6] register commands never start two-wire traffic
// [R7] ten byte registers at addresses 0x00..0x09
// [R8] write is 0x20, address, value
// [R9] one write updates exactly one register
// [R10] read is 0x21, address, ignored filler
// [R11] register value follows the filler byte
// [R12] 0x18 plus byte sets bit order
// [R13] 0x81 msb first, 0x42 lsb first
// [R14] bit order applies both directions
// [R15] other configuration bytes keep current order
// [R16] miso released while deselected
// [R17] pause two-wire master during a command
// [R18] no own-address ack during a command; own_addr_ack_block is raised only while twowire_master_busy is low
// [R19] deselect drops a partial command
module sscp_device (
  // serial link
  sscp_link_if.dev                                   link,
  // system clock and reset
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  // status sources for read-only registers
  input  wire logic [7:0]                            twowire_transfer_status,
  input  wire logic [7:0]                            receive_buffer_count,
  // two-wire engine coordination
  input  wire logic                                  twowire_master_busy,
  output logic                                       twowire_pause,
  output logic                                       own_addr_ack_block,
  // register contents to the rest of the device
  output wire logic [sscp_pkg::NUM_REGS-1:0][7:0]    reg_value
);
  // link domain state
  logic                      frame_rst_n;
  logic [2:0]                bit_cnt_r;
  logic [6:0]                rx_sh_r;
  logic [7:0]                byte_in;
  logic                      byte_done;
  sscp_pkg::sscp_dev_state_t state_r;
  sscp_pkg::sscp_dev_state_t state_nxt;
  logic [7:0]                addr_r;
  logic                      busy_r;
  logic                      lsb_first_r;
  logic                      wr_tgl_r;
  logic [7:0]                wr_addr_q;
  logic [7:0]                wr_data_q;
  logic                      rd_tgl_r;
  logic [7:0]                rd_addr_q;
  logic                      rd_ack_s;
  logic                      reply_ok;
  logic [2:0]                bit_idx;
  logic                      miso_r;
  // system domain state
  logic                      wr_tgl_s;
  logic                      wr_seen_r;
  logic                      wr_pulse;
  logic                      rd_tgl_s;
  logic                      rd_seen_r;
  logic                      rd_pulse;
  logic [7:0]                rd_data_r;
  logic                      busy_s;
  logic [7:0]                regs_r [sscp_pkg::NUM_REGS];
  logic [sscp_pkg::NUM_REGS-1:0][7:0] ro_value;

  // deselect clears all frame state asynchronously, clock may be stopped
  assign frame_rst_n = presetn & ~link.ss_n; // [R1] [R19]
  assign byte_done   = (bit_cnt_r == 3'h7);
  // last bit joins the shifted bits in the selected order
  assign byte_in     = lsb_first_r ? {link.mosi, rx_sh_r} : {rx_sh_r, link.mosi}; // [R14]

  // bit counter and receive shifter, mosi sampled on rising clock
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_r <= 3'h0;
      rx_sh_r   <= 7'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r   <= lsb_first_r ? {link.mosi, rx_sh_r[6:1]} : {rx_sh_r[5:0], link.mosi}; // [R14]
    end
  end

  // command sequencing at each byte boundary
  always_comb begin
    state_nxt = state_r;
    if (byte_done) begin
      case (state_r)
        sscp_pkg::DS_CMD: begin
          if (byte_in == sscp_pkg::CMD_WRITE_REG) begin
            state_nxt = sscp_pkg::DS_WR_ADDR; // [R8]
          end else if (byte_in == sscp_pkg::CMD_READ_REG) begin
            state_nxt = sscp_pkg::DS_RD_ADDR; // [R10]
          end else if (byte_in == sscp_pkg::CMD_LINK_CFG) begin
            state_nxt = sscp_pkg::DS_CFG; // [R12]
          end else begin
            state_nxt = sscp_pkg::DS_CMD;
          end
        end
        sscp_pkg::DS_WR_ADDR:  state_nxt = sscp_pkg::DS_WR_DATA;
        sscp_pkg::DS_WR_DATA:  state_nxt = sscp_pkg::DS_CMD; // [R9]
        sscp_pkg::DS_RD_ADDR:  state_nxt = sscp_pkg::DS_RD_FILL;
        sscp_pkg::DS_RD_FILL:  state_nxt = sscp_pkg::DS_RD_REPLY; // [R10]
        sscp_pkg::DS_RD_REPLY: state_nxt = sscp_pkg::DS_CMD;
        sscp_pkg::DS_CFG:      state_nxt = sscp_pkg::DS_CMD;
        default:               state_nxt = sscp_pkg::DS_CMD;
      endcase
    end
  end

  // decoder state, address byte and command-in-progress flag
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state_r <= sscp_pkg::DS_CMD; // [R19]
      addr_r  <= 8'h00;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (byte_done && state_r == sscp_pkg::DS_WR_ADDR) begin
        addr_r <= byte_in;
      end
      busy_r  <= byte_done ? (state_nxt != sscp_pkg::DS_CMD) : 1'b1;
    end
  end

  // bit order survives deselect; unknown bytes leave it alone
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      lsb_first_r <= sscp_pkg::LSB_FIRST_RESET;
    end else if (byte_done && state_r == sscp_pkg::DS_CFG) begin
      if (byte_in == sscp_pkg::CFG_MSB_FIRST) begin
        lsb_first_r <= 1'b0; // [R13]
      end else if (byte_in == sscp_pkg::CFG_LSB_FIRST) begin
        lsb_first_r <= 1'b1; // [R13]
      end else begin
        lsb_first_r <= lsb_first_r; // [R15]
      end
    end
  end

  // write launch: address and value held stable, then a toggle
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      wr_tgl_r  <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else if (byte_done && state_r == sscp_pkg::DS_WR_DATA) begin
      wr_addr_q <= addr_r; // [R8]
      wr_data_q <= byte_in;
      wr_tgl_r  <= ~wr_tgl_r; // [R9]
    end
  end

  // read launch: address held stable, then a toggle
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      rd_tgl_r  <= 1'b0;
      rd_addr_q <= 8'h00;
    end else if (byte_done && state_r == sscp_pkg::DS_RD_ADDR) begin
      rd_addr_q <= byte_in;
      rd_tgl_r  <= ~rd_tgl_r;
    end
  end

  // read answer comes back during the filler byte
  sscp_sync u_rd_ack_sync (
    .clk   (link.sclk),
    .rst_n (presetn),
    .d     (rd_seen_r),
    .q     (rd_ack_s)
  );

  assign reply_ok = (rd_ack_s == rd_tgl_r);
  assign bit_idx  = lsb_first_r ? bit_cnt_r : (3'h7 - bit_cnt_r); // [R14]

  // miso changes on the falling clock; only the reply slot carries data
  always_ff @(negedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      miso_r <= 1'b0;
    end else begin
      miso_r <= (state_r == sscp_pkg::DS_RD_REPLY) && reply_ok && rd_data_r[bit_idx]; // [R11]
    end
  end

  assign link.miso    = miso_r;
  assign link.miso_oe = ~link.ss_n; // [R16]

  // crossings into the system clock
  sscp_sync u_wr_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (wr_tgl_r),
    .q     (wr_tgl_s)
  );
  sscp_sync u_rd_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (rd_tgl_r),
    .q     (rd_tgl_s)
  );
  sscp_sync u_busy_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (busy_r),
    .q     (busy_s)
  );

  assign wr_pulse = wr_tgl_s ^ wr_seen_r;
  assign rd_pulse = rd_tgl_s ^ rd_seen_r;

  // status inputs shown by the read-only registers
  always_comb begin
    ro_value = '0;
    ro_value[sscp_pkg::ADDR_TWOWIRE_TRANSFER_STATUS] = twowire_transfer_status;
    ro_value[sscp_pkg::ADDR_RECEIVE_BUFFER_COUNT]    = receive_buffer_count;
  end

  // register file, one entry per address; writes never reach two-wire start
  for (genvar i = 0; i < sscp_pkg::NUM_REGS; i++) begin : g_reg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        regs_r[i] <= sscp_pkg::REG_RESET[i];
      end else if (sscp_pkg::REG_READ_ONLY[i]) begin
        regs_r[i] <= ro_value[i];
      end else if (wr_pulse && (wr_addr_q == 8'(i))) begin
        regs_r[i] <= wr_data_q; // [R7] [R6]
      end
    end
    assign reg_value[i] = regs_r[i];
  end

  // event edges and read capture; unmapped addresses read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_seen_r <= 1'b0;
      rd_seen_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      wr_seen_r <= wr_tgl_s;
      rd_seen_r <= rd_tgl_s;
      if (rd_pulse) begin
        rd_data_r <= (rd_addr_q <= sscp_pkg::LAST_REG_ADDR) ? regs_r[rd_addr_q[3:0]] : 8'h00; // [R7]
      end
    end
  end

  // two-wire coordination while a command is in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      twowire_pause      <= 1'b0;
      own_addr_ack_block <= 1'b0;
    end else begin
      twowire_pause      <= busy_s & twowire_master_busy; // [R17]
      own_addr_ack_block <= busy_s & ~twowire_master_busy; // [R18]
    end
  end
endmodule : sscp_device

//--- hdl/sscp_host.sv
// host end: apb-programmed serial master sending one byte per order
`timescale 1ns/1ps
module sscp_host (
  // serial link
  sscp_link_if.host                link,
  // apb slave
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr
);
  sscp_pkg::sscp_host_state_t state_r;
  logic       sclk_r;
  logic       ss_n_r;
  logic       mosi_r;
  logic [7:0] tx_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_data_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] half_cnt_r;
  logic       keep_r;
  logic       lsb_first_r;
  logic [7:0] half_cfg_r;
  logic [7:0] half;
  logic       half_done;
  logic       miso_s;
  logic       apb_wr;
  logic       start;
  logic [2:0] next_idx;

  // miso crosses from the device clock
  sscp_sync u_miso_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (link.miso_line),
    .q     (miso_s)
  );

  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign apb_wr    = psel & penable & pwrite;
  assign start     = apb_wr && (paddr == sscp_pkg::HOST_ADDR_XFER) && (state_r == sscp_pkg::HS_IDLE);
  assign half      = (half_cfg_r < sscp_pkg::HOST_HALF_MIN) ? sscp_pkg::HOST_HALF_MIN : half_cfg_r; // [R5]
  assign half_done = (half_cnt_r == 8'h01);
  assign next_idx  = lsb_first_r ? (bit_cnt_r + 3'h1) : (3'h6 - bit_cnt_r);

  // configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsb_first_r <= sscp_pkg::HOST_LSB_RESET;
      half_cfg_r  <= sscp_pkg::HOST_HALF_RESET;
    end else if (apb_wr && paddr == sscp_pkg::HOST_ADDR_CONFIG) begin
      lsb_first_r <= pwdata[sscp_pkg::CFG_LSB_BIT];
      half_cfg_r  <= pwdata[sscp_pkg::CFG_HALF_LSB +: 8];
    end
  end

  // read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        sscp_pkg::HOST_ADDR_STATUS: prdata <= {30'h0, ~ss_n_r, state_r != sscp_pkg::HS_IDLE};
        sscp_pkg::HOST_ADDR_RXDATA: prdata <= {24'h00_0000, rx_data_r};
        sscp_pkg::HOST_ADDR_CONFIG: prdata <= {16'h0000, half_cfg_r, 7'h00, lsb_first_r};
        default:                    prdata <= 32'h0000_0000;
      endcase
    end
  end

  // byte sequencer driving clock, select and mosi
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= sscp_pkg::HS_IDLE;
      sclk_r     <= 1'b1; // [R3]
      ss_n_r     <= 1'b1;
      mosi_r     <= 1'b1;
      tx_r       <= 8'h00;
      rx_sh_r    <= 8'h00;
      rx_data_r  <= 8'h00;
      bit_cnt_r  <= 3'h0;
      half_cnt_r <= 8'h00;
      keep_r     <= 1'b0;
    end else begin
      half_cnt_r <= half_done ? half : (half_cnt_r - 8'h01);
      case (state_r)
        sscp_pkg::HS_IDLE: begin
          half_cnt_r <= half;
          if (start) begin
            tx_r      <= pwdata[7:0];
            keep_r    <= pwdata[sscp_pkg::XFER_KEEP_BIT]; // [R4] [R8] [R10] [R12]
            bit_cnt_r <= 3'h0;
            ss_n_r    <= 1'b0;
            state_r   <= sscp_pkg::HS_LEAD;
          end
        end
        sscp_pkg::HS_LEAD: if (half_done) begin
          sclk_r  <= 1'b0; // [R2]
          mosi_r  <= lsb_first_r ? tx_r[0] : tx_r[7];
          state_r <= sscp_pkg::HS_LOW;
        end
        sscp_pkg::HS_LOW: if (half_done) begin
          sclk_r  <= 1'b1;
          rx_sh_r <= lsb_first_r ? {miso_s, rx_sh_r[7:1]} : {rx_sh_r[6:0], miso_s};
          state_r <= sscp_pkg::HS_HIGH;
        end
        sscp_pkg::HS_HIGH: if (half_done) begin
          if (bit_cnt_r == 3'h7) begin
            rx_data_r <= rx_sh_r;
            state_r   <= keep_r ? sscp_pkg::HS_IDLE : sscp_pkg::HS_TRAIL;
          end else begin
            sclk_r    <= 1'b0;
            mosi_r    <= tx_r[next_idx];
            bit_cnt_r <= bit_cnt_r + 3'h1;
            state_r   <= sscp_pkg::HS_LOW;
          end
        end
        sscp_pkg::HS_TRAIL: if (half_done) begin
          ss_n_r  <= 1'b1;
          state_r <= sscp_pkg::HS_IDLE;
        end
        default: state_r <= sscp_pkg::HS_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.ss_n = ss_n_r;
  assign link.mosi = mosi_r;
endmodule : sscp_host

//--- hdl/sscp_link_if.sv
// four-wire serial link joining the host end and the device end
`timescale 1ns/1ps
interface sscp_link_if;
  logic sclk;
  logic mosi;
  logic ss_n;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // released miso reads high through the pull-up
  assign miso_line = miso_oe ? miso : 1'b1;

  modport dev (
    input  sclk,
    input  mosi,
    input  ss_n,
    output miso,
    output miso_oe
  );

  modport host (
    output sclk,
    output mosi,
    output ss_n,
    input  miso_line
  );
endinterface : sscp_link_if

//--- hdl/sscp_pkg.sv
// shared constants and types for the serial command port, both ends
package sscp_pkg;

  // device register map, one byte address each
  localparam int NUM_REGS                    = 10;
  localparam logic [7:0] LAST_REG_ADDR       = 8'h09;
  localparam int ADDR_IO_DIRECTION_CONFIG    = 8'h00;
  localparam int ADDR_IO_PIN_STATE           = 8'h01;
  localparam int ADDR_TWOWIRE_CLOCK_DIVIDER  = 8'h02;
  localparam int ADDR_TWOWIRE_TIMEOUT_CONFIG = 8'h03;
  localparam int ADDR_TWOWIRE_TRANSFER_STATUS = 8'h04;
  localparam int ADDR_TWOWIRE_OWN_ADDRESS    = 8'h05;
  localparam int ADDR_RECEIVE_BUFFER_COUNT   = 8'h06;
  localparam int ADDR_IO_CONFIG_EXTRA        = 8'h07;
  localparam int ADDR_EDGE_INTERRUPT_CONFIG  = 8'h08;
  localparam int ADDR_TWOWIRE_EXTRA_TIMEOUTS = 8'h09;

  // reset values, index 9 first
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0, 8'h00, 8'h00};
  // registers that mirror device status instead of storing writes
  localparam logic [NUM_REGS-1:0] REG_READ_ONLY = 10'h050;

  // command and configuration bytes
  localparam logic [7:0] CMD_WRITE_REG = 8'h20;
  localparam logic [7:0] CMD_READ_REG  = 8'h21;
  localparam logic [7:0] CMD_LINK_CFG  = 8'h18;
  localparam logic [7:0] CFG_MSB_FIRST = 8'h81;
  localparam logic [7:0] CFG_LSB_FIRST = 8'h42;
  localparam logic       LSB_FIRST_RESET = 1'b0;

  // host apb register map
  localparam logic [11:0] HOST_ADDR_XFER   = 12'h000;
  localparam logic [11:0] HOST_ADDR_STATUS = 12'h004;
  localparam logic [11:0] HOST_ADDR_RXDATA = 12'h008;
  localparam logic [11:0] HOST_ADDR_CONFIG = 12'h00C;
  localparam int XFER_KEEP_BIT  = 8;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_SEL_BIT   = 1;
  localparam int CFG_LSB_BIT    = 0;
  localparam int CFG_HALF_LSB   = 8;
  localparam logic       HOST_LSB_RESET  = 1'b0;
  localparam logic [7:0] HOST_HALF_RESET = 8'h04;
  localparam logic [7:0] HOST_HALF_MIN   = 8'h03;

  // device link decoder states
  typedef enum logic [2:0] {
    DS_CMD, DS_WR_ADDR, DS_WR_DATA, DS_RD_ADDR, DS_RD_FILL, DS_RD_REPLY, DS_CFG
  } sscp_dev_state_t;

  // host byte sequencer states
  typedef enum logic [2:0] {
    HS_IDLE, HS_LEAD, HS_LOW, HS_HIGH, HS_TRAIL
  } sscp_host_state_t;

endpackage : sscp_pkg

//--- hdl/sscp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sscp_sync (
  // destination clock
  input  wire logic clk,
  input  wire logic rst_n,
  // level in and out
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sscp_sync
